// ---- common/frame_wd_pkg.sv ----
// constants and types shared by the frame watchdog and sync source block
package frame_wd_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_IRQ_PENDING = 8'h04;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0C;
  localparam logic [7:0] OFS_FRAME_TIME = 8'h10;
  localparam logic [7:0] OFS_LAST_SYNC = 8'h14;
  // config register field positions
  localparam int unsigned CFG_WDT_BIT = 4;
  localparam int unsigned CFG_TTSYNC_BIT = 3;
  localparam int unsigned CFG_EVEN_BIT = 2;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [4:0] CFG_WMASK = 5'h1C;
  // interrupt bit positions
  localparam int unsigned IRQ_EOF_BIT = 0;
  localparam int unsigned IRQ_SYNC_TB_BIT = 1;
  localparam int unsigned IRQ_W = 2;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // frame timer
  localparam int unsigned FT_W = 16;
  localparam logic [15:0] FT_RESET = 16'h0000;
  localparam logic [15:0] FT_ONE = 16'h0001;
  // mode code of synchronize with data word
  localparam logic [4:0] MC_SYNC_DATA = 5'h11;
  // timer resolution: 100 us per lsb at a 20 ns clock
  localparam int unsigned TICK_PERIOD_NS = 100000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_CYCLES_DEF = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] TICK_CNT_RESET = 16'h0000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [0:0] {
    TMR_IDLE = 1'b0,
    TMR_RUN = 1'b1
  } timer_state_t;
endpackage

// ---- logic/frame_timer.sv ----
// 16-bit frame down counter with single expiry pulse
`timescale 1ns/1ps
module frame_timer
  import frame_wd_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic start,
  output logic [15:0] count,
  output logic running,
  output logic expire
);
  timer_state_t state_reg;
  timer_state_t state_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic expire_reg;
  wire last_step = (state_reg == TMR_RUN) && tick && (count_reg == FT_ONE);
  wire dec_step = (state_reg == TMR_RUN) && tick && (count_reg != FT_RESET);

  always_comb begin
    count_next = count_reg;
    state_next = state_reg;
    // a reload while running keeps the timer going: that is how the watchdog is fed
    if (load) begin
      count_next = load_value;
    end else if (dec_step) begin
      count_next = count_reg - FT_ONE;
    end
    case (state_reg)
      TMR_IDLE: begin
        if (start) begin
          state_next = TMR_RUN;
        end
      end
      TMR_RUN: begin
        // stops at zero; expiry fires once only
        if ((last_step && !load) || (count_reg == FT_RESET && !load)) begin
          state_next = TMR_IDLE;
        end
      end
      default: begin
        state_next = TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= TMR_IDLE;
      count_reg <= FT_RESET;
      expire_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      expire_reg <= last_step && !load;
    end
  end

  assign count = count_reg;
  assign running = (state_reg == TMR_RUN);
  assign expire = expire_reg;
endmodule

// ---- logic/sync_word_select.sv ----
// chooses the data word sent with each bus message
`timescale 1ns/1ps
module sync_word_select
  import frame_wd_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic msg_req,
  input wire logic msg_is_mode,
  input wire logic [4:0] msg_mode_code,
  input wire logic sync_data_from_timebase,
  input wire logic [15:0] ram_word,
  input wire logic [15:0] time_base_low,
  input wire logic timetag_sync_source_enable,
  input wire logic even_timetag_force,
  output logic tx_valid,
  output logic [15:0] tx_word,
  output logic wb_en,
  output logic [15:0] wb_data,
  output logic from_timebase
);
  logic tx_valid_reg;
  logic [15:0] tx_word_reg;
  logic wb_en_reg;
  logic from_tb_reg;
  wire is_sync17 = msg_is_mode && (msg_mode_code == MC_SYNC_DATA);
  // time base used only for sync mode data with both enables set
  wire use_tb = is_sync17 && timetag_sync_source_enable && sync_data_from_timebase;
  wire lsb_val = time_base_low[0] & ~even_timetag_force;
  wire [15:0] tb_word = {time_base_low[15:1], lsb_val};
  wire [15:0] sel_word = use_tb ? tb_word : ram_word;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_valid_reg <= 1'b0;
      tx_word_reg <= FT_RESET;
      wb_en_reg <= 1'b0;
      from_tb_reg <= 1'b0;
    end else begin
      tx_valid_reg <= msg_req;
      if (msg_req) begin
        tx_word_reg <= sel_word;
      end
      wb_en_reg <= msg_req && use_tb;
      from_tb_reg <= msg_req && use_tb;
    end
  end

  assign tx_valid = tx_valid_reg;
  assign tx_word = tx_word_reg;
  assign wb_en = wb_en_reg;
  assign wb_data = tx_word_reg;
  assign from_timebase = from_tb_reg;
endmodule

// ---- logic/frame_watchdog_sync.sv ----
// bus controller frame watchdog and sync mode data source with apb registers
`timescale 1ns/1ps
module frame_watchdog_sync
  import frame_wd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic clock,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sequencer instruction strobes
  input wire logic load_frame_timer_op,
  input wire logic [15:0] frame_timer_param,
  input wire logic start_frame_timer_op,
  // message data request from the sequencer
  input wire logic msg_req,
  input wire logic msg_is_mode,
  input wire logic [4:0] msg_mode_code,
  input wire logic sync_data_from_timebase,
  input wire logic [15:0] ram_word,
  input wire logic [15:0] time_base_low,
  output logic tx_valid,
  output logic [15:0] tx_word,
  output logic ram_wb_en,
  output logic [15:0] ram_wb_data,
  // interrupt
  output logic irq
);

  // configuration and interrupt state
  logic [4:0] config_reg;
  logic [4:0] config_next;
  logic [IRQ_W-1:0] pending_reg;
  logic [IRQ_W-1:0] pending_next;
  logic [IRQ_W-1:0] enable_reg;
  logic [IRQ_W-1:0] enable_next;
  logic irq_reg;
  logic [15:0] last_sync_reg;

  // apb handshake: one wait state so the answer comes from flip-flops
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rdata_mux;

  // 100 us prescaler
  logic [15:0] tick_cnt_reg;
  logic [15:0] tick_cnt_next;
  logic tick_reg;

  // frame timer and selector outputs
  logic [15:0] ft_count;
  logic ft_expire;
  logic sel_from_tb;
  logic sel_valid;
  logic [15:0] sel_word;

  wire frame_watchdog_enable = config_reg[CFG_WDT_BIT];
  wire timetag_sync_source_enable = config_reg[CFG_TTSYNC_BIT];
  wire even_timetag_force = config_reg[CFG_EVEN_BIT];

  // bus decode
  wire access = psel && penable;
  wire done = access && pready_reg;
  wire wr_done = done && pwrite;
  wire hit_config = (paddr == OFS_CONFIG);
  wire hit_pending = (paddr == OFS_IRQ_PENDING);
  wire hit_enable = (paddr == OFS_IRQ_ENABLE);
  wire hit_clear = (paddr == OFS_IRQ_CLEAR);
  wire hit_frame = (paddr == OFS_FRAME_TIME);
  wire hit_last = (paddr == OFS_LAST_SYNC);
  wire mapped = hit_config || hit_pending || hit_enable || hit_clear || hit_frame || hit_last;
  // read-only registers refuse writes, the clear register refuses reads
  wire ro_write = pwrite && (hit_pending || hit_last);
  wire wo_read = !pwrite && hit_clear;
  wire bad_access = !mapped || ro_write || wo_read;
  // the answer is prepared in the first access cycle and shown in the second
  wire answer = access && !pready_reg;
  wire rd_capture = answer && !pwrite;

  wire wr_config = wr_done && hit_config;
  wire wr_enable = wr_done && hit_enable;
  wire wr_clear = wr_done && hit_clear;
  wire wr_frame = wr_done && hit_frame;

  // software may also load the frame time directly; the sequencer op wins on a tie
  wire ft_load = load_frame_timer_op || wr_frame;
  wire [15:0] ft_load_value = load_frame_timer_op ? frame_timer_param : pwdata[15:0];

  // end of frame only when the watchdog and its interrupt enable are both on
  wire eof_armed = frame_watchdog_enable && enable_reg[IRQ_EOF_BIT];
  wire eof_set = ft_expire && eof_armed;
  wire [IRQ_W-1:0] irq_set = {sel_from_tb, eof_set};
  // ones written to the clear register drop their pending bits, zeros leave them
  wire [IRQ_W-1:0] irq_clr = wr_clear ? pwdata[IRQ_W-1:0] : IRQ_RESET;
  wire [IRQ_W-1:0] irq_level_next = pending_next & enable_next;

  // one wrap every TICK_CYCLES clocks makes one timer lsb
  wire tick_wrap = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

  always_comb begin
    tick_cnt_next = tick_cnt_reg + 16'h0001;
    if (tick_wrap) begin
      tick_cnt_next = TICK_CNT_RESET;
    end
  end

  always_comb begin
    config_next = config_reg;
    // reserved bits are masked so they always read back as zero
    if (wr_config) begin
      config_next = pwdata[4:0] & CFG_WMASK;
    end
  end

  always_comb begin
    enable_next = enable_reg;
    if (wr_enable) begin
      enable_next = pwdata[IRQ_W-1:0];
    end
  end

  // a new event in the same cycle as its clear is kept
  always_comb begin
    pending_next = (pending_reg & ~irq_clr) | irq_set;
  end

  // read words; bits above each register read as zero
  wire [31:0] rd_config = {27'h0, config_reg};
  wire [31:0] rd_pending = {30'h0, pending_reg};
  wire [31:0] rd_enable = {30'h0, enable_reg};
  wire [31:0] rd_frame = {16'h0000, ft_count};
  wire [31:0] rd_last = {16'h0000, last_sync_reg};

  // unmapped and write-only addresses fall through to zero
  always_comb begin
    rdata_mux = DATA_ZERO;
    case (1'b1)
      hit_config: begin
        rdata_mux = rd_config;
      end
      hit_pending: begin
        rdata_mux = rd_pending;
      end
      hit_enable: begin
        rdata_mux = rd_enable;
      end
      hit_frame: begin
        rdata_mux = rd_frame;
      end
      hit_last: begin
        rdata_mux = rd_last;
      end
      default: begin
        rdata_mux = DATA_ZERO;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= TICK_CNT_RESET;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // the prescaler free-runs, so the first lsb after a start may be short by up to one tick
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_wrap;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      config_reg <= CFG_RESET;
    end else begin
      config_reg <= config_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enable_reg <= IRQ_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pending_reg <= IRQ_RESET;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // taken from the next values so irq moves together with the pending bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |irq_level_next;
    end
  end

  // keeps the last word sent from the time base so software can see what went out
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      last_sync_reg <= FT_RESET;
    end else if (sel_from_tb) begin
      last_sync_reg <= sel_word;
    end
  end

  // ready stands for one cycle only, the master drops its request right after it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= answer;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= answer && bad_access;
    end
  end

  // read data is taken in the first access cycle, so a read has no side effect
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata_reg <= DATA_ZERO;
    end else begin
      if (rd_capture) begin
        prdata_reg <= rdata_mux;
      end
    end
  end

  frame_timer frame_timer_inst (
    .clock(clock),
    .arst_n(arst_n),
    .tick(tick_reg),
    .load(ft_load),
    .load_value(ft_load_value),
    .start(start_frame_timer_op),
    .count(ft_count),
    .running(),
    .expire(ft_expire)
  );

  sync_word_select sync_word_select_inst (
    .clock(clock),
    .arst_n(arst_n),
    .msg_req(msg_req),
    .msg_is_mode(msg_is_mode),
    .msg_mode_code(msg_mode_code),
    .sync_data_from_timebase(sync_data_from_timebase),
    .ram_word(ram_word),
    .time_base_low(time_base_low),
    .timetag_sync_source_enable(timetag_sync_source_enable),
    .even_timetag_force(even_timetag_force),
    .tx_valid(sel_valid),
    .tx_word(sel_word),
    .wb_en(ram_wb_en),
    .wb_data(ram_wb_data),
    .from_timebase(sel_from_tb)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_valid = sel_valid;
  assign tx_word = sel_word;
  assign irq = irq_reg;
endmodule

// ---- dv/frame_watchdog_sync_properties.sv ----
// port-level checks for the frame watchdog and sync source block
`timescale 1ns/1ps
module frame_watchdog_sync_properties
  import frame_wd_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic load_frame_timer_op,
  input wire logic [15:0] frame_timer_param,
  input wire logic start_frame_timer_op,
  input wire logic msg_req,
  input wire logic msg_is_mode,
  input wire logic [4:0] msg_mode_code,
  input wire logic sync_data_from_timebase,
  input wire logic [15:0] ram_word,
  input wire logic [15:0] time_base_low,
  input wire logic tx_valid,
  input wire logic [15:0] tx_word,
  input wire logic ram_wb_en,
  input wire logic [15:0] ram_wb_data,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // config bit3 is internal, so only the per-message half of the select is visible
  wire sync_sel = msg_is_mode && msg_mode_code == MC_SYNC_DATA && sync_data_from_timebase;

  chk_tx_after_req: assert property (msg_req |=> tx_valid)
    else $error("no word after message request");
  chk_tx_without_req: assert property (!msg_req |=> !tx_valid)
    else $error("word without message request");
  chk_ram_path: assert property (msg_req && !sync_sel |=> tx_word == $past(ram_word) && !ram_wb_en)
    else $error("non sync message not sent from ram");
  chk_wb_cause: assert property (ram_wb_en |-> $past(msg_req) && $past(sync_sel))
    else $error("time base used outside sync mode");
  chk_wb_copy: assert property (ram_wb_en |-> tx_valid && ram_wb_data == tx_word)
    else $error("write back differs from sent word");
  chk_timebase_word: assert property (ram_wb_en |-> ((tx_word ^ $past(time_base_low)) >> 1) == 16'h0000)
    else $error("sent word is not the time base");
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer not one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");

  cover property (ram_wb_en);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule

// ---- dv/msg_source_model.sv ----
// sequencer side model: ram data word and free running time base
`timescale 1ns/1ps
module msg_source_model
(
  input wire logic clock,
  input wire logic arst_n,
  output logic [15:0] ram_word,
  output logic [15:0] time_base_low
);
  // ram word flips every cycle so a late or early capture shows
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ram_word <= 16'h5AC3;
      time_base_low <= 16'h0000;
    end else begin
      ram_word <= ~ram_word;
      time_base_low <= time_base_low + 16'h0001;
    end
  end
endmodule

// ---- dv/frame_watchdog_sync_tb.sv ----
// self-checking bench for the frame watchdog and sync source block
`timescale 1ns/1ps
module frame_watchdog_sync_tb
  import frame_wd_pkg::*;
;
  localparam int unsigned TICKS = 4;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, msg_req = 1'b0, msg_is_mode = 1'b0;
  logic load_frame_timer_op = 1'b0, start_frame_timer_op = 1'b0, sync_data_from_timebase = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] frame_timer_param = 16'h0, ram_word, time_base_low, tx_word, ram_wb_data, tbs, rws, ex, last_tb;
  logic [4:0] msg_mode_code = 5'h00;
  logic pready, pslverr, tx_valid, ram_wb_en, irq, err, use_tb;
  int fails = 0, checks = 0, cycles = 0;

  frame_watchdog_sync #(.TICK_CYCLES(TICKS)) frame_watchdog_sync_inst (.*);
  msg_source_model msg_source_model_inst (.*);

  initial forever #10 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    check(rd, want);
  endtask

  task automatic msg(input logic m, input logic [4:0] c, input logic b);
    @(posedge clock);
    msg_req <= 1'b1;
    msg_is_mode <= m;
    msg_mode_code <= c;
    sync_data_from_timebase <= b;
    @(posedge clock);
    tbs = time_base_low;
    rws = ram_word;
    msg_req <= 1'b0;
    @(posedge clock);
  endtask

  task automatic ft(input logic [15:0] v, input logic s);
    @(posedge clock);
    load_frame_timer_op <= 1'b1;
    frame_timer_param <= v;
    @(posedge clock);
    load_frame_timer_op <= 1'b0;
    start_frame_timer_op <= s;
    @(posedge clock);
    start_frame_timer_op <= 1'b0;
  endtask

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    read_check(OFS_CONFIG, 32'h0);
    read_check(OFS_IRQ_ENABLE, 32'h0);
    read_check(OFS_LAST_SYNC, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, OFS_IRQ_PENDING, 32'h3);
    check(err, 32'h1);
    apb(1'b1, OFS_CONFIG, 32'hFFFFFFFF);
    read_check(OFS_CONFIG, 32'h1C);
    // odd passes of the upper half add a cycle, but all four passes that send the time base still catch it even
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, OFS_CONFIG, {28'h0, i[0], i[2], 2'h0});
      if (i[4] && i[0]) @(posedge clock);
      msg(!(i[3] && i[4]), (i[3] && !i[4]) ? 5'h12 : MC_SYNC_DATA, i[1]);
      use_tb = i[0] && i[1] && !i[3];
      ex = use_tb ? (tbs & (i[2] ? 16'hFFFE : 16'hFFFF)) : rws;
      check(tx_valid, 32'h1);
      check(tx_word, ex);
      check(ram_wb_en, use_tb);
      if (use_tb) begin
        check(ram_wb_data, ex);
        last_tb = ex;
      end
    end
    read_check(OFS_LAST_SYNC, {16'h0000, last_tb});
    read_check(OFS_IRQ_PENDING, 32'h2);
    check(irq, 32'h0);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h2);
    repeat (2) @(posedge clock);
    check(irq, 32'h1);
    apb(1'b1, OFS_IRQ_CLEAR, 32'h2);
    repeat (2) @(posedge clock);
    check(irq, 32'h0);
    read_check(OFS_IRQ_PENDING, 32'h0);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h1);
    apb(1'b1, OFS_CONFIG, 32'h10);
    ft(16'h0007, 1'b0);
    read_check(OFS_FRAME_TIME, 32'h7);
    ft(16'h0006, 1'b1);
    repeat (8) @(posedge clock);
    ft(16'h0006, 1'b0);
    repeat (8) @(posedge clock);
    read_check(OFS_IRQ_PENDING, 32'h0);
    repeat (40) @(posedge clock);
    read_check(OFS_FRAME_TIME, 32'h0);
    read_check(OFS_IRQ_PENDING, 32'h1);
    check(irq, 32'h1);
    apb(1'b1, OFS_IRQ_CLEAR, 32'h1);
    repeat (20) @(posedge clock);
    read_check(OFS_IRQ_PENDING, 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h0);
    ft(16'h0002, 1'b1);
    repeat (20) @(posedge clock);
    read_check(OFS_IRQ_PENDING, 32'h0);
    give_verdict();
  end
endmodule

bind frame_watchdog_sync frame_watchdog_sync_properties frame_watchdog_sync_properties_inst (.*);
